// ==== rtl/oag_pkg.sv ====
package oag_pkg;
    // prefix byte values seen ahead of an opcode
    localparam logic [7:0]  PFX_SECOND_INDEX = 8'h90;  // second_index_prefix
    localparam logic [7:0]  PFX_INDIRECT     = 8'h92;  // indirect_conversion_prefix
    // opcode high nibble groups
    localparam logic [3:0]  GRP_REL          = 4'h2;   // relative jumps
    localparam logic [3:0]  GRP_RMW_SDIR     = 4'h3;   // read-modify-write, short direct
    localparam logic [3:0]  GRP_INH_A        = 4'h4;   // inherent on accumulator
    localparam logic [3:0]  GRP_INH_X        = 4'h5;   // inherent on index
    localparam logic [3:0]  GRP_RMW_SIDX     = 4'h6;   // read-modify-write, short indexed
    localparam logic [3:0]  GRP_RMW_NIDX     = 4'h7;   // read-modify-write, no offset
    localparam logic [3:0]  GRP_IMM          = 4'hA;   // immediate
    localparam logic [3:0]  GRP_SDIR         = 4'hB;   // short direct
    localparam logic [3:0]  GRP_LDIR         = 4'hC;   // long direct
    localparam logic [3:0]  GRP_LIDX         = 4'hD;   // long indexed
    localparam logic [3:0]  GRP_SIDX         = 4'hE;   // short indexed
    localparam logic [3:0]  GRP_NIDX         = 4'hF;   // no offset indexed
    localparam logic [7:0]  BYTE_ZERO        = 8'h00;
    localparam logic [6:0]  NINTH_PAD        = 7'h00;
    localparam logic [15:0] WORD_ONE         = 16'h0001;
    localparam logic [15:0] WORD_ZERO        = 16'h0000;
    localparam logic [2:0]  MAX_LEN          = 3'h4;   // prefix, opcode, two more bytes

    typedef enum logic [3:0] {
        M_INH, M_IMM, M_SDIR, M_LDIR, M_NIDX, M_SIDX, M_LIDX,
        M_SIND, M_LIND, M_SIIX, M_LIIX, M_REL, M_RELI
    } mode_t;

    // opcode nibble plus indirect prefix to addressing mode
    function automatic mode_t decode_mode(input logic [3:0] grp, input logic ind);
        mode_t m;
        m = M_INH;
        case (grp)
            GRP_REL:      m = ind ? M_RELI : M_REL;
            GRP_RMW_SDIR: m = ind ? M_SIND : M_SDIR;   // short forms only
            GRP_RMW_SIDX: m = ind ? M_SIIX : M_SIDX;
            GRP_RMW_NIDX: m = M_NIDX;
            GRP_IMM:      m = M_IMM;
            GRP_SDIR:     m = ind ? M_SIND : M_SDIR;
            GRP_LDIR:     m = ind ? M_LIND : M_LDIR;
            GRP_LIDX:     m = ind ? M_LIIX : M_LIDX;
            GRP_SIDX:     m = ind ? M_SIIX : M_SIDX;
            GRP_NIDX:     m = M_NIDX;
            default:      m = M_INH;
        endcase
        return m;
    endfunction : decode_mode

    // unsigned sum of a base word and an index byte
    function automatic logic [15:0] idx_add(input logic [15:0] base, input logic [7:0] idx);
        return base + {BYTE_ZERO, idx};
    endfunction : idx_add
endpackage : oag_pkg

`timescale 1ns/1ps
`default_nettype none
module operand_address_former
    import oag_pkg::*;
(
    input  wire logic [3:0]  mode,   // addressing mode
    input  wire logic [15:0] base,   // fetched address, offset or pointer value
    input  wire logic [7:0]  idx,    // selected index register
    input  wire logic [15:0] pc,     // address after the instruction
    output logic      [15:0] ea      // effective address
);
    logic [8:0] short_sum;  // nine-bit short indexed sum
    always_comb begin
        short_sum = {1'b0, base[7:0]} + {1'b0, idx};
        ea = WORD_ZERO;
        case (mode_t'(mode))
            M_SDIR, M_SIND: ea = {BYTE_ZERO, base[7:0]};
            M_LDIR, M_LIND: ea = base;
            M_NIDX:         ea = {BYTE_ZERO, idx};
            M_SIDX, M_SIIX: ea = {NINTH_PAD, short_sum};
            M_LIDX, M_LIIX: ea = idx_add(base, idx);
            M_REL, M_RELI:  ea = pc + {{8{base[7]}}, base[7:0]}; // signed displacement
            default:        ea = WORD_ZERO;                     // inherent and immediate
        endcase
    end
endmodule : operand_address_former
`default_nettype wire

// ==== rtl/cpu_operand_address_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_address_generator
    import oag_pkg::*;
(
    input  wire logic        CLK,       // cpu clock
    input  wire logic        RST,       // synchronous reset, active high
    input  wire logic        START,     // pulse: decode instruction at PC_IN
    input  wire logic [15:0] PC_IN,     // program_counter at instruction start
    input  wire logic [7:0]  X_IN,      // first index register
    input  wire logic [7:0]  Y_IN,      // second index register
    output logic      [15:0] MEM_ADDR,  // memory read address
    output logic             MEM_RD,    // read request, held until MEM_ACK
    input  wire logic [7:0]  MEM_DATA,  // read data, valid with MEM_ACK
    input  wire logic        MEM_ACK,   // read completed
    output logic             DONE,      // pulse: results valid
    output logic      [15:0] EA,        // operand address or jump target
    output logic      [7:0]  OPERAND,   // immediate operand value
    output logic      [7:0]  OPCODE,    // opcode after any prefix
    output logic      [3:0]  MODE,      // decoded addressing mode
    output logic      [2:0]  LENGTH,    // instruction bytes incl. prefix
    output logic      [15:0] NEXT_PC,   // program_counter after instruction
    output logic             USE_Y,     // second index register selected
    output logic             BUSY       // decode in progress
);
    typedef enum logic [2:0] {S_IDLE, S_OPC, S_B1, S_B2, S_PHI, S_PLO, S_CALC} state_t;

    typedef struct packed {
        state_t      st;      // sequencer state
        logic [15:0] start;   // first byte address
        logic [15:0] pc;      // next byte to fetch
        logic [7:0]  opc;     // opcode
        logic        use_y;   // second index selected
        logic        ind;     // indirect prefix seen
        mode_t       mode;    // addressing mode
        logic [7:0]  b1;      // byte after opcode
        logic [7:0]  hi;      // pointer high byte
        logic [15:0] base;    // value handed to the former
        logic [15:0] maddr;   // memory address out
        logic        mrd;     // memory request out
        logic        done;    // done pulse out
        logic [15:0] ea;      // result address
        logic [7:0]  operand; // immediate value
        logic [2:0]  len;     // length out
        logic        busy;    // busy out
    } regs_t;

    regs_t       r;         // registered state
    regs_t       next_r;    // next state
    mode_t       dm;        // mode decoded from the incoming opcode
    logic [15:0] former_ea; // combinational address from the former
    logic [15:0] pc_inc;    // fetch address plus one

    operand_address_former u_former (
        .mode (r.mode),
        .base (r.base),
        .idx  (r.use_y ? Y_IN : X_IN),
        .pc   (r.pc),
        .ea   (former_ea)
    );

    // sequencer: one byte per acknowledged read
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        pc_inc = r.pc + WORD_ONE;
        dm = decode_mode(MEM_DATA[7:4], r.ind);
        unique case (r.st)
            S_IDLE: begin
                if (START) begin
                    next_r.start = PC_IN;
                    next_r.pc    = PC_IN;
                    next_r.maddr = PC_IN;
                    next_r.mrd   = 1'b1;
                    next_r.use_y = 1'b0;
                    next_r.ind   = 1'b0;
                    next_r.busy  = 1'b1;
                    next_r.st    = S_OPC;
                end
            end
            S_OPC: begin
                if (MEM_ACK) begin
                    next_r.pc    = pc_inc;
                    next_r.maddr = pc_inc;
                    // one prefix at most; a second one is taken as opcode
                    if (MEM_DATA == PFX_SECOND_INDEX && !r.use_y && !r.ind) begin
                        next_r.use_y = 1'b1;
                    end else if (MEM_DATA == PFX_INDIRECT && !r.use_y && !r.ind) begin
                        next_r.ind = 1'b1;
                    end else begin
                        next_r.opc  = MEM_DATA;
                        next_r.mode = dm;
                        if (dm == M_INH || dm == M_NIDX) begin
                            next_r.mrd = 1'b0;    // opcode alone
                            next_r.st  = S_CALC;
                        end else begin
                            next_r.st = S_B1;
                        end
                    end
                end
            end
            S_B1: begin
                if (MEM_ACK) begin
                    next_r.b1   = MEM_DATA;
                    next_r.pc   = pc_inc;
                    next_r.base = {BYTE_ZERO, MEM_DATA};
                    if (r.mode == M_LDIR || r.mode == M_LIDX) begin
                        next_r.maddr = pc_inc;
                        next_r.st    = S_B2;
                    end else if (r.mode == M_LIND || r.mode == M_LIIX) begin
                        next_r.maddr = {BYTE_ZERO, MEM_DATA};  // page zero pointer
                        next_r.st    = S_PHI;
                    end else if (r.mode == M_SIND || r.mode == M_SIIX || r.mode == M_RELI) begin
                        next_r.maddr = {BYTE_ZERO, MEM_DATA};
                        next_r.st    = S_PLO;
                    end else begin
                        next_r.operand = MEM_DATA;  // immediate value or short field
                        next_r.mrd     = 1'b0;
                        next_r.st      = S_CALC;
                    end
                end
            end
            S_B2: begin
                if (MEM_ACK) begin
                    next_r.base = {r.b1, MEM_DATA};  // high byte first
                    next_r.pc   = pc_inc;
                    next_r.mrd  = 1'b0;
                    next_r.st   = S_CALC;
                end
            end
            S_PHI: begin
                if (MEM_ACK) begin
                    next_r.hi    = MEM_DATA;
                    next_r.maddr = r.maddr + WORD_ONE;  // low half of pointer word
                    next_r.st    = S_PLO;
                end
            end
            S_PLO: begin
                if (MEM_ACK) begin
                    // word pointer high first; byte pointer has zero high half
                    if (r.mode == M_LIND || r.mode == M_LIIX) begin
                        next_r.base = {r.hi, MEM_DATA};
                    end else begin
                        next_r.base = {BYTE_ZERO, MEM_DATA};
                    end
                    next_r.mrd = 1'b0;
                    next_r.st  = S_CALC;
                end
            end
            S_CALC: begin
                next_r.ea   = former_ea;
                next_r.len  = 3'(r.pc - r.start);
                next_r.done = 1'b1;
                next_r.busy = 1'b0;
                next_r.st   = S_IDLE;
            end
        endcase
    end

    // state register; reset gives an idle, quiet bus
    always_ff @(posedge CLK) begin
        if (RST) begin
            r <= '{st: S_IDLE, mode: M_INH, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign MEM_ADDR = r.maddr;
    assign MEM_RD   = r.mrd;
    assign DONE     = r.done;
    assign EA       = r.ea;
    assign OPERAND  = r.operand;
    assign OPCODE   = r.opc;
    assign MODE     = r.mode;
    assign LENGTH   = r.len;
    assign NEXT_PC  = r.pc;
    assign USE_Y    = r.use_y;
    assign BUSY     = r.busy;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    done_single_a: assert property (DONE |-> !BUSY ##1 !DONE)
        else $error("done lasted more than one cycle");
    inherent_len_a: assert property (DONE && MODE == M_INH |-> LENGTH == 3'(USE_Y) + 3'(r.ind) + 3'h1)
        else $error("inherent length wrong");
    imm_len_a: assert property (DONE && MODE == M_IMM |-> LENGTH == 3'(USE_Y) + 3'(r.ind) + 3'h2)
        else $error("immediate length wrong");
    long_len_a: assert property (DONE && (MODE == M_LDIR || MODE == M_LIDX) |-> LENGTH >= 3'h3 && LENGTH <= MAX_LEN)
        else $error("long form length wrong");
    page_zero_a: assert property (DONE && (MODE == M_SDIR || MODE == M_SIND || MODE == M_NIDX) |-> EA[15:8] == BYTE_ZERO)
        else $error("short address left page zero");
    short_sum_a: assert property (DONE && (MODE == M_SIDX || MODE == M_SIIX) |-> EA[15:9] == NINTH_PAD)
        else $error("short indexed sum too wide");
    ptr_page_a: assert property (MEM_RD && (r.st == S_PLO || r.st == S_PHI) && r.mode != M_LIND && r.mode != M_LIIX |-> MEM_ADDR[15:8] == BYTE_ZERO)
        else $error("pointer read outside page zero");
    word_order_a: assert property (r.st == S_B2 && MEM_ACK |=> r.base == {$past(r.b1), $past(MEM_DATA)})
        else $error("word byte order wrong");
    rmw_short_a: assert property (r.st == S_OPC && MEM_ACK && !r.use_y && !r.ind && MEM_DATA[7:4] == GRP_RMW_SDIR |=> r.mode == M_SDIR)
        else $error("read-modify-write decoded long");
    prefix_ind_a: assert property (r.st == S_OPC && MEM_ACK && r.ind && MEM_DATA[7:4] == GRP_LDIR |=> r.mode == M_LIND)
        else $error("indirect prefix not applied");
endmodule : cpu_operand_address_generator
`default_nettype wire

// ==== tb/code_memory.sv ====
`timescale 1ns/1ps
`default_nettype none
module code_memory (
    input  wire logic        CLK,       // cpu clock
    input  wire logic        RST,       // synchronous reset, active high
    input  wire logic [15:0] MEM_ADDR,  // read address from the decoder
    input  wire logic        MEM_RD,    // read request level
    input  wire logic [3:0]  STALL,     // wait cycles before each answer
    output logic      [7:0]  MEM_DATA,  // read data, meaningful with the ack only
    output logic             MEM_ACK    // read completed
);
    logic [7:0] mem [0:65535];  // code, pointers and operands
    logic [3:0] wait_cnt;       // cycles waited on the current read
    logic [7:0] filler;         // junk shown whenever no answer is given

    // answer once the chosen number of wait cycles has passed
    assign MEM_ACK  = MEM_RD && (wait_cnt == STALL);
    // outside the ack the data keeps changing, so a late sample cannot pass by luck
    assign MEM_DATA = MEM_ACK ? mem[MEM_ADDR] : filler;

    // wait counter restarts after every answer; filler shifts left each cycle, taking in its inverted top bit
    always_ff @(posedge CLK) begin
        if (RST || !MEM_RD || MEM_ACK) begin
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
        filler <= RST ? 8'hA5 : {filler[6:0], ~filler[7]};
    end
endmodule : code_memory
`default_nettype wire

// ==== tb/cpu_operand_address_generator_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_address_generator_test import oag_pkg::*;;
    logic clk, rst, start, mem_rd, mem_ack, done, use_y, busy;  // single-bit lines
    logic [15:0] pc_in, mem_addr, ea, next_pc;                  // address buses
    logic [7:0]  x_in, y_in, mem_data, operand, opcode;         // byte buses
    logic [3:0]  mode, stall;                                   // mode code, memory wait
    logic [2:0]  length;                                        // instruction length
    int          mismatches, checks, reads;                     // counters

    cpu_operand_address_generator i_cpu_operand_address_generator (
        .CLK(clk), .RST(rst), .START(start), .PC_IN(pc_in), .X_IN(x_in), .Y_IN(y_in),
        .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_DATA(mem_data), .MEM_ACK(mem_ack),
        .DONE(done), .EA(ea), .OPERAND(operand), .OPCODE(opcode), .MODE(mode),
        .LENGTH(length), .NEXT_PC(next_pc), .USE_Y(use_y), .BUSY(busy));
    code_memory i_code_memory (
        .CLK(clk), .RST(rst), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .STALL(stall),
        .MEM_DATA(mem_data), .MEM_ACK(mem_ack));

    // clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // every acknowledged read counts toward the fetch total
    always @(posedge clk) begin
        if (mem_rd === 1'b1 && mem_ack === 1'b1) begin
            reads = reads + 1;
        end
    end

    task automatic cmp_addr(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_addr

    task automatic cmp_field(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_field

    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // place the bytes, run one decode, judge length, next address, mode, address, fetches
    task automatic decode(input logic [15:0] pc, input logic [31:0] code, input logic [2:0] n,
                          input logic [3:0] exp_mode, input logic [15:0] exp_ea, input int exp_reads);
        int k;
        logic [7:0] exp_opc;  // opcode byte behind any prefix
        for (k = 0; k < n; k++) begin
            i_code_memory.mem[pc + 16'(k)] = code[31 - 8 * k -: 8];
        end
        reads = 0;
        start = 1'b1;
        pc_in = pc;
        @(posedge clk);
        #1;
        start = 1'b0;
        cmp_field({7'h00, busy}, 8'h01);
        k = 0;
        // bounded wait for the end of the decode
        while (done !== 1'b1) begin
            if (k++ == 200) begin
                mismatches++;
                finish_test();
            end
            @(posedge clk);
            #1;
        end
        cmp_field({5'h00, length}, {5'h00, n});
        cmp_addr(next_pc, pc + {13'h0000, n});
        cmp_field({4'h0, mode}, {4'h0, exp_mode});
        cmp_addr(ea, exp_ea);
        cmp_field(8'(reads), 8'(exp_reads));
        exp_opc = (code[31:24] == PFX_SECOND_INDEX || code[31:24] == PFX_INDIRECT) ? code[23:16] : code[31:24];
        cmp_field(opcode, exp_opc);
        cmp_field({7'h00, use_y}, {7'h00, code[31:24] == PFX_SECOND_INDEX});
        @(posedge clk);
        #1;
        cmp_field({7'h00, done}, 8'h00);
    endtask : decode

    task automatic scen_inherent_immediate;
        decode(16'h0100, 32'h4C000000, 3'h1, M_INH, 16'h0000, 1);
        decode(16'h0101, 32'hA6550000, 3'h2, M_IMM, 16'h0000, 2);
        cmp_field(operand, 8'h55);
    endtask : scen_inherent_immediate

    // short direct, then long direct behind a slow memory
    task automatic scen_direct;
        decode(16'h0110, 32'hB6100000, 3'h2, M_SDIR, 16'h0010, 2);
        stall = 4'h2;
        decode(16'h0120, 32'hC6123400, 3'h3, M_LDIR, 16'h1234, 3);
        stall = 4'h0;
    endtask : scen_direct

    // index at its top value to push the short sum over page zero, then 8'h80 for a carry in the long sum
    task automatic scen_indexed;
        x_in = 8'hFF;
        decode(16'h0130, 32'hF6000000, 3'h1, M_NIDX, 16'h00FF, 1);
        decode(16'h0131, 32'hE6FF0000, 3'h2, M_SIDX, 16'h01FE, 2);
        x_in = 8'h80;
        decode(16'h0140, 32'hD612F000, 3'h3, M_LIDX, 16'h1370, 3);
    endtask : scen_indexed

    task automatic scen_indirect;
        stall = 4'h3;
        i_code_memory.mem[16'h0040] = 8'h77;
        decode(16'h0150, 32'h92B64000, 3'h3, M_SIND, 16'h0077, 4);
        i_code_memory.mem[16'h0040] = 8'hAB;
        i_code_memory.mem[16'h0041] = 8'hCD;
        decode(16'h0160, 32'h92C64000, 3'h3, M_LIND, 16'hABCD, 5);
        stall = 4'h0;
    endtask : scen_indirect

    task automatic scen_indirect_indexed;
        x_in = 8'hFF;
        i_code_memory.mem[16'h0050] = 8'hFF;
        decode(16'h0170, 32'h92E65000, 3'h3, M_SIIX, 16'h01FE, 4);
        x_in = 8'h10;
        i_code_memory.mem[16'h0060] = 8'h12;
        i_code_memory.mem[16'h0061] = 8'hF0;
        decode(16'h0178, 32'h92D66000, 3'h3, M_LIIX, 16'h1300, 5);
    endtask : scen_indirect_indexed

    // second index selected by prefix; first index left different
    task automatic scen_second_index;
        x_in = 8'h01;
        y_in = 8'hF0;
        decode(16'h0180, 32'h90E61000, 3'h3, M_SIDX, 16'h0100, 3);
        cmp_field({7'h00, use_y}, 8'h01);
    endtask : scen_second_index

    // read-modify-write groups stay short, also with the indirect prefix
    task automatic scen_rmw;
        i_code_memory.mem[16'h0040] = 8'h77;
        decode(16'h0190, 32'h3C200000, 3'h2, M_SDIR, 16'h0020, 2);
        decode(16'h0192, 32'h923C4000, 3'h3, M_SIND, 16'h0077, 4);
        x_in = 8'h01;
        decode(16'h0196, 32'h6C080000, 3'h2, M_SIDX, 16'h0009, 2);
        decode(16'h0198, 32'h7C000000, 3'h1, M_NIDX, 16'h0001, 1);
    endtask : scen_rmw

    // reset in the middle of a slow fetch, then a clean decode
    task automatic scen_reset;
        stall = 4'h3;
        start = 1'b1;
        pc_in = 16'h0120;
        @(posedge clk);
        #1;
        start = 1'b0;
        @(posedge clk);
        #1;
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        stall = 4'h0;
        cmp_field({6'h00, mem_rd, busy}, 8'h00);
        cmp_field({7'h00, done}, 8'h00);
        cmp_field({4'h0, mode}, 8'h00);
        cmp_addr(mem_addr, 16'h0000);
        decode(16'h0120, 32'hC6123400, 3'h3, M_LDIR, 16'h1234, 3);
    endtask : scen_reset

    // backward displacements, direct and from memory
    task automatic scen_relative;
        decode(16'h0200, 32'h20FE0000, 3'h2, M_REL, 16'h0200, 2);
        i_code_memory.mem[16'h0040] = 8'h80;
        decode(16'h0210, 32'h92204000, 3'h3, M_RELI, 16'h0193, 4);
    endtask : scen_relative

    initial begin
        rst = 1'b1;
        start = 1'b0;
        pc_in = 16'h0000;
        x_in = 8'h00;
        y_in = 8'h00;
        stall = 4'h0;
        mismatches = 0;
        checks = 0;
        reads = 0;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        scen_inherent_immediate();
        scen_direct();
        scen_indexed();
        scen_indirect();
        scen_indirect_indexed();
        scen_second_index();
        scen_rmw();
        scen_relative();
        scen_reset();
        finish_test();
    end
endmodule : cpu_operand_address_generator_test
`default_nettype wire
